// ---- design/ppfm_pkg.sv ----
// Purpose: constants and types for the port pin function multiplexer
// Assumes: one 100 MHz clock, synchronous active-low reset
// Notes: register map chosen for this block; see the tags below
package ppfm_pkg;

    // ==========================================================
    // register offsets
    localparam logic [4:0] PPFM_DATA_A   = 5'h00;
    localparam logic [4:0] PPFM_DATA_B   = 5'h01;
    localparam logic [4:0] PPFM_DATA_C   = 5'h02;
    localparam logic [4:0] PPFM_DATA_D   = 5'h03;
    localparam logic [4:0] PPFM_DIR_A    = 5'h04;
    localparam logic [4:0] PPFM_DIR_B    = 5'h05;
    localparam logic [4:0] PPFM_DIR_C    = 5'h06;
    localparam logic [4:0] PPFM_DIR_D    = 5'h07;
    localparam logic [4:0] PPFM_DATA_E   = 5'h08;
    localparam logic [4:0] PPFM_DIR_E    = 5'h09;
    localparam logic [4:0] PPFM_PULL_A   = 5'h0a;
    localparam logic [4:0] PPFM_PULL_C   = 5'h0b;
    localparam logic [4:0] PPFM_PULL_D   = 5'h0c;
    localparam logic [4:0] PPFM_KBD_EN   = 5'h0d;
    localparam logic [4:0] PPFM_ADC_EN   = 5'h0e;
    localparam logic [4:0] PPFM_FUNC_EN  = 5'h0f;
    localparam logic [4:0] PPFM_STATUS   = 5'h10;

    // ==========================================================
    // function enable fields
    localparam int PPFM_FE_SPI  = 0;
    localparam int PPFM_FE_TIM0 = 1;
    localparam int PPFM_FE_SCI  = 5;
    localparam int PPFM_FE_OSC  = 6;

    // ==========================================================
    // reset values, masks and counts
    localparam logic [7:0] PPFM_RST_ZERO   = 8'h00;
    localparam logic [6:0] PPFM_C_SMALL_MK = 7'h1f;
    localparam logic [2:0] PPFM_RST_STRETCH = 3'h7;

    typedef enum logic [2:0] {
        PPFM_RS_IDLE  = 3'b001,
        PPFM_RS_DRIVE = 3'b010,
        PPFM_RS_WAIT  = 3'b100
    } ppfm_rst_state_t;

endpackage

// ---- design/ppfm_sync.sv ----
`timescale 1ns/1ps
// Purpose: two flip-flop synchroniser for asynchronous levels
// Assumes: one clock
// Notes: first stage read only by the second
module ppfm_sync #(
    parameter int W = 1
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] d_i,
    input  wire logic [W-1:0] rst_val_i,
    output logic      [W-1:0] q_o
);
    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s1_reg <= rst_val_i;
            s2_reg <= rst_val_i;
        end else begin
            s1_reg <= d_i;
            s2_reg <= s1_reg;
        end
    end

    assign q_o = s2_reg;
endmodule // ppfm_sync

// ---- design/ppfm_rst_ctl.sv ----
`timescale 1ns/1ps
// Purpose: bidirectional reset pin control
// Assumes: internal reset sources synchronous to clk_i
// Notes: stretches the drive so the pin is seen low
module ppfm_rst_ctl
    import ppfm_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_n_i,
    input  wire logic int_rst_i,
    input  wire logic pin_low_i,
    output logic      drive_low_o,
    output logic      sys_rst_o
);
    ppfm_rst_state_t st_reg, st_next;
    logic [2:0]      cnt_reg, cnt_next;
    logic            drv_reg, drv_next;
    logic            srst_reg, srst_next;

    always_comb begin
        st_next   = st_reg;
        cnt_next  = cnt_reg;
        drv_next  = 1'b0;
        srst_next = pin_low_i | int_rst_i;
        case (st_reg)
            PPFM_RS_IDLE: begin
                if (int_rst_i) begin
                    st_next  = PPFM_RS_DRIVE;
                    cnt_next = PPFM_RST_STRETCH;
                    drv_next = 1'b1;
                end
            end
            PPFM_RS_DRIVE: begin
                drv_next = 1'b1;
                if (int_rst_i) begin
                    cnt_next = PPFM_RST_STRETCH;
                end else if (cnt_reg == 3'h0) begin
                    st_next  = PPFM_RS_WAIT;
                    drv_next = 1'b0;
                end else begin
                    cnt_next = cnt_reg - 3'h1;
                end
            end
            PPFM_RS_WAIT: begin
                if (int_rst_i) begin
                    st_next  = PPFM_RS_DRIVE;
                    cnt_next = PPFM_RST_STRETCH;
                    drv_next = 1'b1;
                end else if (!pin_low_i) begin
                    st_next = PPFM_RS_IDLE;
                end
            end
            default: st_next = PPFM_RS_IDLE;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            st_reg   <= PPFM_RS_IDLE;
            cnt_reg  <= 3'h0;
            drv_reg  <= 1'b0;
            srst_reg <= 1'b1;
        end else begin
            st_reg   <= st_next;
            cnt_reg  <= cnt_next;
            drv_reg  <= drv_next;
            srst_reg <= srst_next;
        end
    end

    assign drive_low_o = drv_reg;
    assign sys_rst_o   = srst_reg;
endmodule // ppfm_rst_ctl

// ---- design/ppfm_top.sv ----
`timescale 1ns/1ps
// Purpose: pin function multiplexer for five general-purpose ports
// Assumes: pins resolved outside from out/oe; pin inputs synchronous
// Notes: peripherals live outside; this block only steers pins
module ppfm_top
    import ppfm_pkg::*;
(
    input  wire logic       clk_i,
    input  wire logic       rst_n_i,
    input  wire logic       large_pkg_i,
    // register port
    input  wire logic [4:0] addr_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    output logic      [7:0] rdata_o,
    // pins
    input  wire logic [7:0] port_a_pins_i,
    output logic      [7:0] port_a_pins_o,
    output logic      [7:0] port_a_pins_oe_o,
    output logic      [7:0] port_a_pull_o,
    input  wire logic [7:0] port_b_pins_i,
    output logic      [7:0] port_b_pins_o,
    output logic      [7:0] port_b_pins_oe_o,
    input  wire logic [6:0] port_c_pins_i,
    output logic      [6:0] port_c_pins_o,
    output logic      [6:0] port_c_pins_oe_o,
    output logic      [6:0] port_c_pull_o,
    input  wire logic [7:0] port_d_pins_i,
    output logic      [7:0] port_d_pins_o,
    output logic      [7:0] port_d_pins_oe_o,
    output logic      [7:0] port_d_pull_o,
    input  wire logic [4:0] port_e_pins_i,
    output logic      [4:0] port_e_pins_o,
    output logic      [4:0] port_e_pins_oe_o,
    input  wire logic       reset_pin_i,
    output logic            reset_pin_o,
    output logic            reset_pin_oe_o,
    input  wire logic       ext_irq_pin_i,
    // peripheral side
    output logic      [7:0] keyboard_irq_inputs_o,
    output logic      [7:0] converter_channel_inputs_o,
    output logic      [7:0] converter_channel_sel_o,
    input  wire logic [3:0] spi_out_i,
    input  wire logic [3:0] spi_oe_i,
    output logic      [3:0] spi_in_o,
    input  wire logic [3:0] tim_out_i,
    input  wire logic [3:0] tim_oe_i,
    output logic      [3:0] tim_in_o,
    input  wire logic       sci_txd_i,
    output logic            sci_rxd_o,
    output logic            crystal_enable_o,
    input  wire logic       int_rst_i,
    output logic            sys_rst_o,
    output logic            ext_irq_o
);
    // ==========================================================
    // registers
    logic [7:0] data_a_reg, data_a_next, dir_a_reg, dir_a_next;
    logic [7:0] data_b_reg, data_b_next, dir_b_reg, dir_b_next;
    logic [6:0] data_c_reg, data_c_next, dir_c_reg, dir_c_next;
    logic [7:0] data_d_reg, data_d_next, dir_d_reg, dir_d_next;
    logic [4:0] data_e_reg, data_e_next, dir_e_reg, dir_e_next;
    logic [7:0] pull_a_reg, pull_a_next, pull_d_reg, pull_d_next;
    logic [6:0] pull_c_reg, pull_c_next;
    logic [7:0] kbd_reg, kbd_next, adc_reg, adc_next, fen_reg, fen_next;
    logic [7:0] rdata_reg, rdata_next;
    logic [6:0] c_mask;
    logic [6:0] pin_c_in;
    logic       irq_sync;
    logic       rst_drive;
    logic       sys_rst;

    function automatic logic [7:0] ext7(input logic [6:0] v);
        ext7 = {1'b0, v};
    endfunction

    assign c_mask   = large_pkg_i ? 7'h7f : PPFM_C_SMALL_MK;
    assign pin_c_in = port_c_pins_i & c_mask;

    // ==========================================================
    // register writes and reads
    always_comb begin
        data_a_next = data_a_reg;
        dir_a_next  = dir_a_reg;
        data_b_next = data_b_reg;
        dir_b_next  = dir_b_reg;
        data_c_next = data_c_reg;
        dir_c_next  = dir_c_reg;
        data_d_next = data_d_reg;
        dir_d_next  = dir_d_reg;
        data_e_next = data_e_reg;
        dir_e_next  = dir_e_reg;
        pull_a_next = pull_a_reg;
        pull_c_next = pull_c_reg;
        pull_d_next = pull_d_reg;
        kbd_next    = kbd_reg;
        adc_next    = adc_reg;
        fen_next    = fen_reg;
        rdata_next  = PPFM_RST_ZERO;
        if (wr_i) begin
            case (addr_i)
                PPFM_DATA_A:  data_a_next = wdata_i;
                PPFM_DATA_B:  data_b_next = wdata_i;
                PPFM_DATA_C:  data_c_next = wdata_i[6:0];
                PPFM_DATA_D:  data_d_next = wdata_i;
                PPFM_DIR_A:   dir_a_next  = wdata_i;
                PPFM_DIR_B:   dir_b_next  = wdata_i;
                PPFM_DIR_C:   dir_c_next  = wdata_i[6:0];
                PPFM_DIR_D:   dir_d_next  = wdata_i;
                PPFM_DATA_E:  data_e_next = wdata_i[4:0];
                PPFM_DIR_E:   dir_e_next  = wdata_i[4:0];
                PPFM_PULL_A:  pull_a_next = wdata_i;
                PPFM_PULL_C:  pull_c_next = wdata_i[6:0];
                PPFM_PULL_D:  pull_d_next = wdata_i;
                PPFM_KBD_EN:  kbd_next    = wdata_i;
                PPFM_ADC_EN:  adc_next    = wdata_i;
                PPFM_FUNC_EN: fen_next    = {1'b0, wdata_i[6:0]};
                default: ;
            endcase
        end
        if (rd_i) begin
            case (addr_i)
                // data reads return pin level on inputs, latch on outputs
                PPFM_DATA_A:  rdata_next = (dir_a_reg & data_a_reg) | (~dir_a_reg & port_a_pins_i);
                PPFM_DATA_B:  rdata_next = (dir_b_reg & data_b_reg) | (~dir_b_reg & port_b_pins_i);
                PPFM_DATA_C:  rdata_next = ext7((dir_c_reg & data_c_reg & c_mask)
                                                | (~dir_c_reg & pin_c_in));
                PPFM_DATA_D:  rdata_next = (dir_d_reg & data_d_reg) | (~dir_d_reg & port_d_pins_i);
                PPFM_DIR_A:   rdata_next = dir_a_reg;
                PPFM_DIR_B:   rdata_next = dir_b_reg;
                PPFM_DIR_C:   rdata_next = ext7(dir_c_reg);
                PPFM_DIR_D:   rdata_next = dir_d_reg;
                PPFM_DATA_E:  rdata_next = {3'h0, (dir_e_reg & data_e_reg)
                                                  | (~dir_e_reg & port_e_pins_i)};
                PPFM_DIR_E:   rdata_next = {3'h0, dir_e_reg};
                PPFM_PULL_A:  rdata_next = pull_a_reg;
                PPFM_PULL_C:  rdata_next = ext7(pull_c_reg);
                PPFM_PULL_D:  rdata_next = pull_d_reg;
                PPFM_KBD_EN:  rdata_next = kbd_reg;
                PPFM_ADC_EN:  rdata_next = adc_reg;
                PPFM_FUNC_EN: rdata_next = fen_reg;
                PPFM_STATUS:  rdata_next = {5'h0, large_pkg_i, rst_drive, irq_sync};
                default:      rdata_next = PPFM_RST_ZERO;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i || sys_rst) begin
            data_a_reg <= PPFM_RST_ZERO;
            dir_a_reg  <= PPFM_RST_ZERO;
            data_b_reg <= PPFM_RST_ZERO;
            dir_b_reg  <= PPFM_RST_ZERO;
            data_c_reg <= 7'h00;
            dir_c_reg  <= 7'h00;
            data_d_reg <= PPFM_RST_ZERO;
            dir_d_reg  <= PPFM_RST_ZERO;
            data_e_reg <= 5'h00;
            dir_e_reg  <= 5'h00;
            pull_a_reg <= PPFM_RST_ZERO;
            pull_c_reg <= 7'h00;
            pull_d_reg <= PPFM_RST_ZERO;
            kbd_reg    <= PPFM_RST_ZERO;
            adc_reg    <= PPFM_RST_ZERO;
            fen_reg    <= PPFM_RST_ZERO;
            rdata_reg  <= PPFM_RST_ZERO;
        end else begin
            data_a_reg <= data_a_next;
            dir_a_reg  <= dir_a_next;
            data_b_reg <= data_b_next;
            dir_b_reg  <= dir_b_next;
            data_c_reg <= data_c_next;
            dir_c_reg  <= dir_c_next;
            data_d_reg <= data_d_next;
            dir_d_reg  <= dir_d_next;
            data_e_reg <= data_e_next;
            dir_e_reg  <= dir_e_next;
            pull_a_reg <= pull_a_next;
            pull_c_reg <= pull_c_next;
            pull_d_reg <= pull_d_next;
            kbd_reg    <= kbd_next;
            adc_reg    <= adc_next;
            fen_reg    <= fen_next;
            rdata_reg  <= rdata_next;
        end
    end

    // ==========================================================
    // reset pin and external interrupt
    ppfm_rst_ctl u_rst (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .int_rst_i   (int_rst_i),
        .pin_low_i   (!reset_pin_i),
        .drive_low_o (rst_drive),
        .sys_rst_o   (sys_rst)
    );

    ppfm_sync #(.W(1)) u_irq (
        .clk_i     (clk_i),
        .rst_n_i   (rst_n_i),
        .d_i       (ext_irq_pin_i),
        .rst_val_i (1'b1),
        .q_o       (irq_sync)
    );

    // ==========================================================
    // pin steering
    logic [7:0] a_out, a_oe, a_pu, b_out, b_oe, d_out, d_oe, d_pu;
    logic [6:0] c_out, c_oe, c_pu;
    logic [4:0] e_out, e_oe;
    logic       spi_on, sci_on, osc_on;
    logic [3:0] tim_on;

    assign spi_on = fen_reg[PPFM_FE_SPI];
    assign tim_on = fen_reg[PPFM_FE_TIM0 +: 4];
    assign sci_on = fen_reg[PPFM_FE_SCI];
    assign osc_on = fen_reg[PPFM_FE_OSC];

    always_comb begin
        a_out = data_a_reg;
        a_oe  = dir_a_reg & ~kbd_reg; // keyboard pins forced to input
        b_out = data_b_reg;
        b_oe  = dir_b_reg & ~adc_reg;
        c_out = data_c_reg & c_mask;
        c_oe  = dir_c_reg & c_mask;
        d_out = data_d_reg;
        d_oe  = dir_d_reg;
        if (spi_on) begin
            d_out[3:0] = spi_out_i;
            d_oe[3:0]  = spi_oe_i;
        end
        for (int i = 0; i < 4; i++) begin
            if (tim_on[i]) begin
                d_out[4+i] = tim_out_i[i];
                d_oe[4+i]  = tim_oe_i[i];
            end
        end
        e_out = data_e_reg;
        e_oe  = dir_e_reg;
        if (sci_on) begin
            e_out[0] = sci_txd_i;
            e_oe[0]  = 1'b1;
            e_oe[1]  = 1'b0;
        end
        if (osc_on) begin
            e_oe[4:3] = 2'b00; // crystal circuit owns pins
        end
        a_pu = pull_a_reg & ~a_oe;
        c_pu = pull_c_reg & ~c_oe & c_mask;
        d_pu = pull_d_reg & ~d_oe;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            port_a_pins_o              <= 8'h00;
            port_a_pins_oe_o           <= 8'h00;
            port_a_pull_o              <= 8'h00;
            port_b_pins_o              <= 8'h00;
            port_b_pins_oe_o           <= 8'h00;
            port_c_pins_o              <= 7'h00;
            port_c_pins_oe_o           <= 7'h00;
            port_c_pull_o              <= 7'h00;
            port_d_pins_o              <= 8'h00;
            port_d_pins_oe_o           <= 8'h00;
            port_d_pull_o              <= 8'h00;
            port_e_pins_o              <= 5'h00;
            port_e_pins_oe_o           <= 5'h00;
            keyboard_irq_inputs_o      <= 8'h00;
            converter_channel_inputs_o <= 8'h00;
            converter_channel_sel_o    <= 8'h00;
            spi_in_o                   <= 4'h0;
            tim_in_o                   <= 4'h0;
            sci_rxd_o                  <= 1'b1;
            crystal_enable_o           <= 1'b0;
            reset_pin_oe_o             <= 1'b0;
            ext_irq_o                  <= 1'b0;
            sys_rst_o                  <= 1'b1;
        end else begin
            port_a_pins_o              <= a_out;
            port_a_pins_oe_o           <= a_oe;
            port_a_pull_o              <= a_pu;
            port_b_pins_o              <= b_out;
            port_b_pins_oe_o           <= b_oe;
            port_c_pins_o              <= c_out;
            port_c_pins_oe_o           <= c_oe;
            port_c_pull_o              <= c_pu;
            port_d_pins_o              <= d_out;
            port_d_pins_oe_o           <= d_oe;
            port_d_pull_o              <= d_pu;
            port_e_pins_o              <= e_out;
            port_e_pins_oe_o           <= e_oe;
            keyboard_irq_inputs_o      <= port_a_pins_i | ~kbd_reg;
            converter_channel_inputs_o <= port_b_pins_i & adc_reg;
            converter_channel_sel_o    <= adc_reg;
            spi_in_o                   <= spi_on ? port_d_pins_i[3:0] : 4'h0;
            tim_in_o                   <= port_d_pins_i[7:4] & tim_on;
            sci_rxd_o                  <= sci_on ? port_e_pins_i[1] : 1'b1;
            crystal_enable_o           <= osc_on;
            reset_pin_oe_o             <= rst_drive;
            ext_irq_o                  <= !irq_sync;
            sys_rst_o                  <= sys_rst;
        end
    end

    assign rdata_o     = rdata_reg;
    assign reset_pin_o = 1'b0;
endmodule // ppfm_top

// ---- sim/ppfm_board.sv ----
// Purpose: board circuitry on one port, resolves each pin level
// Assumes: drv_en_i marks the pins that the board drives
// Notes: a floating pin without pull-up shows the inverse of the device's present out_i value
`timescale 1ns/1ps
module ppfm_board #(
    parameter int W = 8
) (
    input  wire logic [W-1:0] out_i,
    input  wire logic [W-1:0] oe_i,
    input  wire logic [W-1:0] pull_i,
    input  wire logic [W-1:0] drv_i,
    input  wire logic [W-1:0] drv_en_i,
    output logic      [W-1:0] pin_o
);
    // ==========================================================
    // pin resolution, device drive wins
    always_comb begin
        for (int i = 0; i < W; i++) begin
            if (oe_i[i]) begin
                pin_o[i] = out_i[i];
            end else if (drv_en_i[i]) begin
                pin_o[i] = drv_i[i];
            end else if (pull_i[i]) begin
                pin_o[i] = 1'b1;
            end else begin
                pin_o[i] = ~out_i[i];
            end
        end
    end
endmodule // ppfm_board

// ---- sim/ppfm_top_chk.sv ----
// Purpose: port-level checks of the pin multiplexer
// Assumes: bound to ppfm_top
// Notes: sees top-level ports only
`timescale 1ns/1ps
module ppfm_top_chk (
    input wire logic       clk_i,
    input wire logic       rst_n_i,
    input wire logic       large_pkg_i,
    input wire logic [7:0] port_a_pins_oe_o,
    input wire logic [7:0] port_a_pull_o,
    input wire logic [6:0] port_c_pins_oe_o,
    input wire logic [7:0] port_d_pins_oe_o,
    input wire logic [7:0] port_d_pull_o,
    input wire logic [4:0] port_e_pins_oe_o,
    input wire logic       reset_pin_i,
    input wire logic       reset_pin_oe_o,
    input wire logic       ext_irq_pin_i,
    input wire logic       crystal_enable_o,
    input wire logic       int_rst_i,
    input wire logic       sys_rst_o,
    input wire logic       ext_irq_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    // ==========================================================
    // pins
    pull_a_out_a: assert property ((port_a_pull_o & port_a_pins_oe_o) == 8'h00)
        else $error("port a pull on output");
    pull_d_out_a: assert property ((port_d_pull_o & port_d_pins_oe_o) == 8'h00)
        else $error("port d pull on output");
    small_pkg_a: assert property (!large_pkg_i && !$past(large_pkg_i) |->
        port_c_pins_oe_o[6:5] == 2'b00) else $error("port c 5-6 driven");
    crystal_pins_a: assert property (crystal_enable_o && $past(crystal_enable_o) |->
        port_e_pins_oe_o[4:3] == 2'b00) else $error("crystal pins driven");
    // ==========================================================
    // reset pin
    rst_drive_a: assert property (int_rst_i |-> ##2 reset_pin_oe_o)
        else $error("reset pin not driven");
    rst_hold_a: assert property ($fell(int_rst_i) |-> ##1 reset_pin_oe_o [*8])
        else $error("reset drive too short");
    rst_release_a: assert property ($fell(int_rst_i) |-> ##9 !reset_pin_oe_o)
        else $error("reset drive stuck");
    sys_int_a: assert property (int_rst_i |-> ##[1:3] sys_rst_o)
        else $error("internal reset not seen");
    sys_pin_a: assert property (!reset_pin_i |-> ##[1:3] sys_rst_o)
        else $error("reset pin low not seen");
    // ==========================================================
    // external interrupt
    irq_take_a: assert property (!ext_irq_pin_i [*4] |-> ext_irq_o)
        else $error("interrupt missed");
endmodule // ppfm_top_chk

// ---- sim/ppfm_top_tb.sv ----
// Purpose: self-checking bench for the port pin function multiplexer
// Assumes: board models resolve every port's pins
// Notes: outputs are registered
`timescale 1ns/1ps
module ppfm_top_tb;
    import ppfm_pkg::*;
    logic       clk_i = 1'b0;
    logic       rst_n_i = 1'b0;
    logic       large_pkg_i = 1'b1;
    logic [4:0] addr_i = 5'h00;
    logic [7:0] wdata_i = 8'h00;
    logic       wr_i = 1'b0;
    logic       rd_i = 1'b0;
    logic [7:0] rdata_o, keyboard_irq_inputs_o, converter_channel_inputs_o;
    logic [7:0] converter_channel_sel_o;
    logic [7:0] port_a_pins_i, port_a_pins_o, port_a_pins_oe_o, port_a_pull_o;
    logic [7:0] port_b_pins_i, port_b_pins_o, port_b_pins_oe_o;
    logic [6:0] port_c_pins_i, port_c_pins_o, port_c_pins_oe_o, port_c_pull_o;
    logic [7:0] port_d_pins_i, port_d_pins_o, port_d_pins_oe_o, port_d_pull_o;
    logic [4:0] port_e_pins_i, port_e_pins_o, port_e_pins_oe_o;
    logic       reset_pin_i, reset_pin_o, reset_pin_oe_o, ext_irq_o, sys_rst_o;
    logic       sci_rxd_o, crystal_enable_o;
    logic       ext_irq_pin_i = 1'b1;
    logic       ext_rst_low = 1'b0;
    logic       sci_txd_i = 1'b0;
    logic       int_rst_i = 1'b0;
    logic [3:0] spi_out_i = 4'h0, spi_oe_i = 4'h0, tim_out_i = 4'h0, tim_oe_i = 4'h0;
    logic [3:0] spi_in_o, tim_in_o;
    logic [7:0] drv_a = 8'h00, en_a = 8'h00, drv_b = 8'h00, en_b = 8'h00;
    logic [7:0] drv_d = 8'h00, en_d = 8'h00;
    logic [6:0] drv_c = 7'h00, en_c = 7'h00;
    logic [4:0] drv_e = 5'h00, en_e = 5'h00;
    int         mismatches = 0;
    int         cmp_count = 0;

    always #5 clk_i = ~clk_i;
    assign reset_pin_i = reset_pin_oe_o ? reset_pin_o : ~ext_rst_low;

    ppfm_board board_a (.out_i(port_a_pins_o), .oe_i(port_a_pins_oe_o),
        .pull_i(port_a_pull_o), .drv_i(drv_a), .drv_en_i(en_a), .pin_o(port_a_pins_i));
    ppfm_board board_b (.out_i(port_b_pins_o), .oe_i(port_b_pins_oe_o),
        .pull_i(8'h00), .drv_i(drv_b), .drv_en_i(en_b), .pin_o(port_b_pins_i));
    ppfm_board #(.W(7)) board_c (.out_i(port_c_pins_o), .oe_i(port_c_pins_oe_o),
        .pull_i(port_c_pull_o), .drv_i(drv_c), .drv_en_i(en_c), .pin_o(port_c_pins_i));
    ppfm_board board_d (.out_i(port_d_pins_o), .oe_i(port_d_pins_oe_o),
        .pull_i(port_d_pull_o), .drv_i(drv_d), .drv_en_i(en_d), .pin_o(port_d_pins_i));
    ppfm_board #(.W(5)) board_e (.out_i(port_e_pins_o), .oe_i(port_e_pins_oe_o),
        .pull_i(5'h00), .drv_i(drv_e), .drv_en_i(en_e), .pin_o(port_e_pins_i));

    ppfm_top DUT (.*);

    // ==========================================================
    // shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_i);
        wr_i <= 1'b0;
    endtask
    task automatic rd(input logic [4:0] a, output logic [7:0] d);
        @(posedge clk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask
    task automatic conclude();
        $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // ==========================================================
    // scenarios
    task automatic t_pull();
        logic [7:0] d;
        chk({7'h00, sci_rxd_o}, 8'h01);
        rd(PPFM_DIR_A, d);
        chk(d, 8'h00);
        wr(PPFM_PULL_A, 8'hff);
        wr(PPFM_DIR_A, 8'h0f);
        wr(PPFM_PULL_D, 8'hff);
        wr(PPFM_DIR_D, 8'h3c);
        idle(3);
        chk(port_a_pull_o, 8'hf0);
        chk(port_d_pull_o, 8'hc3);
    endtask
    task automatic t_kbd();
        logic [7:0] m;
        wr(PPFM_DIR_A, 8'hff);
        drv_a <= 8'h5a;
        en_a <= 8'hff;
        for (int i = 0; i < 3; i++) begin
            m = (i == 0) ? 8'h00 : (i == 1) ? 8'h81 : 8'hff;
            wr(PPFM_KBD_EN, m);
            idle(5);
            chk(port_a_pins_oe_o, ~m);
            chk(keyboard_irq_inputs_o, ~m | (8'h5a & m));
        end
    endtask
    task automatic t_portd();
        wr(PPFM_DIR_D, 8'h00);
        spi_out_i <= 4'ha;
        spi_oe_i <= 4'hc;
        tim_out_i <= 4'h1;
        tim_oe_i <= 4'h1;
        drv_d <= 8'hff;
        en_d <= 8'hff;
        wr(PPFM_FUNC_EN, 8'h03);
        idle(5);
        chk(port_d_pins_oe_o, 8'h1c);
        chk({3'h0, port_d_pins_o[4:0]}, 8'h1a);
        chk({4'h0, spi_in_o}, 8'h0b);
        chk({4'h0, tim_in_o}, 8'h01);
        tim_oe_i <= 4'hf;
        wr(PPFM_FUNC_EN, 8'h1e);
        idle(5);
        chk(port_d_pins_oe_o, 8'hf0);
    endtask
    task automatic t_adc_sci();
        wr(PPFM_DIR_B, 8'hff);
        drv_b <= 8'hff;
        en_b <= 8'hff;
        wr(PPFM_ADC_EN, 8'h0f);
        wr(PPFM_DIR_E, 8'h1f);
        en_e <= 5'h02;
        idle(5);
        chk(converter_channel_inputs_o, 8'h0f);
        chk(converter_channel_sel_o, 8'h0f);
        chk(port_b_pins_oe_o, 8'hf0);
        for (int i = 0; i < 2; i++) begin
            sci_txd_i <= i[0];
            drv_e <= {3'h0, i[0], 1'b0};
            wr(PPFM_FUNC_EN, 8'h60);
            idle(5);
            chk({3'h0, port_e_pins_oe_o}, 8'h05);
            chk({7'h00, port_e_pins_o[0]}, {7'h00, i[0]});
            chk({7'h00, sci_rxd_o}, {7'h00, i[0]});
            chk({7'h00, crystal_enable_o}, 8'h01);
        end
    endtask
    task automatic t_small();
        logic [7:0] d;
        large_pkg_i <= 1'b0;
        wr(PPFM_DIR_C, 8'h7f);
        idle(4);
        chk({1'b0, port_c_pins_oe_o}, 8'h1f);
        wr(PPFM_DIR_C, 8'h00);
        drv_c <= 7'h7f;
        en_c <= 7'h7f;
        wr(PPFM_PULL_C, 8'hff);
        idle(5);
        rd(PPFM_DATA_C, d);
        chk(d, 8'h1f);
        chk({1'b0, port_c_pull_o}, 8'h1f);
        large_pkg_i <= 1'b1;
        idle(5);
        rd(PPFM_DATA_C, d);
        chk(d, 8'h7f);
        wr(5'h11, 8'hff);
        rd(5'h11, d);
        chk(d, 8'h00);
    endtask
    task automatic t_irq();
        int n;
        #3 ext_irq_pin_i <= 1'b0;
        n = 0;
        while (ext_irq_o !== 1'b1 && n < 8) begin
            idle(1);
            n++;
        end
        chk({7'h00, ext_irq_o}, 8'h01);
        if (n == 8) conclude();
        idle(2);
        ext_irq_pin_i <= 1'b1;
        idle(6);
        chk({7'h00, ext_irq_o}, 8'h00);
    endtask
    task automatic t_resets();
        logic [7:0] d;
        wr(PPFM_DIR_A, 8'hff);
        int_rst_i <= 1'b1;
        idle(2);
        chk({7'h00, reset_pin_oe_o}, 8'h01);
        int_rst_i <= 1'b0;
        idle(16);
        chk({7'h00, reset_pin_oe_o}, 8'h00);
        rd(PPFM_DIR_A, d);
        chk(d, 8'h00);
        wr(PPFM_DIR_A, 8'hff);
        ext_rst_low <= 1'b1;
        idle(3);
        chk({7'h00, sys_rst_o}, 8'h01);
        ext_rst_low <= 1'b0;
        idle(5);
        rd(PPFM_DIR_A, d);
        chk(d, 8'h00);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        repeat (2) @(posedge clk_i);
        rst_n_i <= 1'b1;
        idle(4);
        t_pull();
        t_kbd();
        t_portd();
        t_adc_sci();
        t_small();
        t_irq();
        t_resets();
        conclude();
    end
endmodule // ppfm_top_tb

bind ppfm_top ppfm_top_chk u_chk (.*);
